// >>> rtl/fvec_pkg.sv
package fvec_pkg;

  // feature identifiers decoded by this bank
  localparam logic [7:0]  FID_VEC_CFG      = 8'h09;
  localparam logic [7:0]  FID_ATOMIC       = 8'h0a;
  localparam logic [7:0]  FID_AEN          = 8'h0b;

  // per-vector configuration dword 11 layout
  localparam int          VEC_IDX_LSB      = 0;
  localparam int          VEC_IDX_W        = 16;
  localparam int          COAL_OFF_POS     = 16;

  // atomicity control dword 11 layout
  localparam int          NORM_ATOM_POS    = 0;

  // event enable mask layout
  localparam int          AEN_FW_POS       = 9;
  localparam int          AEN_NS_POS       = 8;
  localparam int          AEN_HEALTH_LSB   = 0;
  localparam int          AEN_HEALTH_W     = 8;
  localparam int          AEN_W            = 10;

  // vectors served by the table
  localparam int          NUM_VEC          = 32;
  localparam int          VEC_SEL_W        = 5;

  // reset values
  localparam logic        COAL_OFF_RST     = 1'b0;
  localparam logic        NORM_ATOM_RST    = 1'b0;
  localparam logic [9:0]  AEN_MASK_RST     = 10'h000;

  // completion status codes
  localparam logic [7:0]  STS_SUCCESS      = 8'h00;
  localparam logic [7:0]  STS_INVALID_FLD  = 8'h02;

  typedef struct packed {
    logic        set;
    logic [7:0]  fid;
    logic [31:0] dw11;
  } fvec_cmd_t;

  typedef struct packed {
    logic [31:0] dw0;
    logic [7:0]  status;
  } fvec_cpl_t;

  typedef struct packed {
    logic        valid;
    logic        admin;
    logic [15:0] vec;
  } fvec_post_t;

endpackage

// >>> rtl/fvec_vec_table.sv
`timescale 1ns/1ps
module fvec_vec_table (
  input  wire logic                         mclk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wr_en_i,
  input  wire logic [fvec_pkg::VEC_SEL_W-1:0] wr_idx_i,
  input  wire logic                         wr_bit_i,
  input  wire logic [fvec_pkg::VEC_SEL_W-1:0] rd_idx_i,
  output logic                              rd_bit_o,
  input  wire logic [fvec_pkg::VEC_SEL_W-1:0] post_idx_i,
  output logic                              post_bit_o,
  output logic [fvec_pkg::NUM_VEC-1:0]      all_o
);

  logic [fvec_pkg::NUM_VEC-1:0] bits_r;

  // coalescing stays on for every vector until the host turns it off
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bits_r <= {fvec_pkg::NUM_VEC{fvec_pkg::COAL_OFF_RST}};
    end else if (wr_en_i) begin
      bits_r[wr_idx_i] <= wr_bit_i;
    end
  end

  assign rd_bit_o   = bits_r[rd_idx_i];
  assign post_bit_o = bits_r[post_idx_i];
  assign all_o      = bits_r;

endmodule

// >>> rtl/fvec_evt_gate.sv
`timescale 1ns/1ps
module fvec_evt_gate #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] lvl_i,
  input  wire logic [W-1:0] en_i,
  output logic [W-1:0]      evt_o
);

  logic [W-1:0] prev_r;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prev_r <= '0;
    end else begin
      prev_r <= lvl_i;
    end
  end

  // one notice per rising edge; a condition that stays high fires only once
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      evt_o <= '0;
    end else begin
      evt_o <= lvl_i & ~prev_r & en_i;
    end
  end

endmodule

// >>> rtl/fvec_feature_cfg.sv
`timescale 1ns/1ps
module fvec_feature_cfg (
  input  wire logic                          mclk_i,
  input  wire logic                          rst_i,
  input  wire logic                          cmd_valid_i,
  input  wire fvec_pkg::fvec_cmd_t           cmd_i,
  input  wire logic [fvec_pkg::NUM_VEC-1:0]  vec_iocq_ok_i,
  input  wire fvec_pkg::fvec_post_t          post_i,
  input  wire logic                          fw_act_start_i,
  input  wire logic                          ns_attr_chg_i,
  input  wire logic [7:0]                    health_warn_i,
  output logic                               cpl_valid_o,
  output fvec_pkg::fvec_cpl_t                cpl_o,
  output logic                               post_valid_o,
  output logic                               post_nocoal_o,
  output logic [fvec_pkg::NUM_VEC-1:0]       coalesce_off_vec_o,
  output logic                               normal_atomicity_off_o,
  output logic                               honor_normal_atomic_o,
  output logic                               aen_fw_act_o,
  output logic                               aen_ns_attr_o,
  output logic [7:0]                         aen_health_o
);

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic                              hit_vec;
  logic                              hit_atom;
  logic                              hit_aen;
  logic [fvec_pkg::VEC_IDX_W-1:0]    cmd_vec_idx;
  logic                              cmd_vec_in_range;
  logic [fvec_pkg::VEC_SEL_W-1:0]    cmd_vec_sel;
  logic                              cmd_vec_ok;
  logic                              cmd_coal_off;

  assign hit_vec  = cmd_valid_i && (cmd_i.fid == fvec_pkg::FID_VEC_CFG);
  assign hit_atom = cmd_valid_i && (cmd_i.fid == fvec_pkg::FID_ATOMIC);
  assign hit_aen  = cmd_valid_i && (cmd_i.fid == fvec_pkg::FID_AEN);

  // index field sits in the low half of dword 11
  assign cmd_vec_idx = cmd_i.dw11[fvec_pkg::VEC_IDX_LSB +: fvec_pkg::VEC_IDX_W];
  assign cmd_vec_in_range = (cmd_vec_idx < 16'(fvec_pkg::NUM_VEC));
  assign cmd_vec_sel = cmd_vec_idx[fvec_pkg::VEC_SEL_W-1:0];
  assign cmd_coal_off = cmd_i.dw11[fvec_pkg::COAL_OFF_POS];

  // a vector with no I/O completion queue behind it is refused as well
  assign cmd_vec_ok = cmd_vec_in_range && vec_iocq_ok_i[cmd_vec_sel];

  // ---------------------------------------------------------------
  // per-vector coalescing table
  // ---------------------------------------------------------------
  logic                              tbl_wr_en;
  logic                              tbl_rd_bit;
  logic                              tbl_post_bit;
  logic [fvec_pkg::NUM_VEC-1:0]      tbl_all;
  logic [fvec_pkg::VEC_SEL_W-1:0]    post_sel;
  logic                              post_in_range;

  // a refused set leaves the table untouched
  assign tbl_wr_en = hit_vec && cmd_i.set && cmd_vec_ok;

  assign post_in_range = (post_i.vec < 16'(fvec_pkg::NUM_VEC));
  assign post_sel      = post_i.vec[fvec_pkg::VEC_SEL_W-1:0];

  fvec_vec_table u_vec_table (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .wr_en_i    (tbl_wr_en),
    .wr_idx_i   (cmd_vec_sel),
    .wr_bit_i   (cmd_coal_off),
    .rd_idx_i   (cmd_vec_sel),
    .rd_bit_o   (tbl_rd_bit),
    .post_idx_i (post_sel),
    .post_bit_o (tbl_post_bit),
    .all_o      (tbl_all)
  );

  // ---------------------------------------------------------------
  // atomicity control
  // ---------------------------------------------------------------
  logic norm_atom_off_r;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      norm_atom_off_r <= fvec_pkg::NORM_ATOM_RST;
    end else if (hit_atom && cmd_i.set) begin
      // only bit 0 is kept; the rest of dword 11 is dropped
      norm_atom_off_r <= cmd_i.dw11[fvec_pkg::NORM_ATOM_POS];
    end
  end

  // ---------------------------------------------------------------
  // asynchronous event enable mask
  // ---------------------------------------------------------------
  logic [fvec_pkg::AEN_W-1:0] aen_mask_r;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      aen_mask_r <= fvec_pkg::AEN_MASK_RST;
    end else if (hit_aen && cmd_i.set) begin
      aen_mask_r <= cmd_i.dw11[fvec_pkg::AEN_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // completion for set and get
  // ---------------------------------------------------------------
  logic                  cpl_valid_nxt;
  fvec_pkg::fvec_cpl_t   cpl_nxt;

  always_comb begin
    cpl_valid_nxt = 1'b0;
    cpl_nxt       = '0;
    if (hit_vec) begin
      cpl_valid_nxt = 1'b1;
      if (!cmd_vec_ok) begin
        cpl_nxt.status = fvec_pkg::STS_INVALID_FLD;
      end else begin
        cpl_nxt.status = fvec_pkg::STS_SUCCESS;
        cpl_nxt.dw0[fvec_pkg::VEC_IDX_LSB +: fvec_pkg::VEC_IDX_W] = cmd_vec_idx;
        // a set echoes the new value, a get the stored one
        cpl_nxt.dw0[fvec_pkg::COAL_OFF_POS] = cmd_i.set ? cmd_coal_off : tbl_rd_bit;
      end
    end else if (hit_atom) begin
      cpl_valid_nxt = 1'b1;
      cpl_nxt.status = fvec_pkg::STS_SUCCESS;
      cpl_nxt.dw0[fvec_pkg::NORM_ATOM_POS] =
        cmd_i.set ? cmd_i.dw11[fvec_pkg::NORM_ATOM_POS] : norm_atom_off_r;
    end else if (hit_aen) begin
      cpl_valid_nxt = 1'b1;
      cpl_nxt.status = fvec_pkg::STS_SUCCESS;
      cpl_nxt.dw0[fvec_pkg::AEN_W-1:0] =
        cmd_i.set ? cmd_i.dw11[fvec_pkg::AEN_W-1:0] : aen_mask_r;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cpl_valid_o <= 1'b0;
      cpl_o       <= '0;
    end else begin
      cpl_valid_o <= cpl_valid_nxt;
      cpl_o       <= cpl_nxt;
    end
  end

  // ---------------------------------------------------------------
  // coalescing verdict per posted completion
  // ---------------------------------------------------------------
  logic post_nocoal_nxt;

  // admin completions bypass coalescing regardless of the table;
  // an unknown vector keeps the default, coalescing on
  always_comb begin
    if (post_i.admin) begin
      post_nocoal_nxt = 1'b1;
    end else if (post_in_range) begin
      post_nocoal_nxt = tbl_post_bit;
    end else begin
      post_nocoal_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      post_valid_o  <= 1'b0;
      post_nocoal_o <= 1'b0;
    end else begin
      post_valid_o  <= post_i.valid;
      post_nocoal_o <= post_i.valid && post_nocoal_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      coalesce_off_vec_o <= '0;
    end else begin
      coalesce_off_vec_o <= tbl_all;
    end
  end

  // ---------------------------------------------------------------
  // atomicity outputs to the write path
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      normal_atomicity_off_o <= fvec_pkg::NORM_ATOM_RST;
      honor_normal_atomic_o  <= ~fvec_pkg::NORM_ATOM_RST;
    end else begin
      normal_atomicity_off_o <= norm_atom_off_r;
      // power-fail limits are always honored; only the normal ones drop
      honor_normal_atomic_o  <= ~norm_atom_off_r;
    end
  end

  // ---------------------------------------------------------------
  // event notification gating
  // ---------------------------------------------------------------
  logic [1:0] misc_lvl;
  logic [1:0] misc_en;
  logic [1:0] misc_evt;

  assign misc_lvl = {fw_act_start_i, ns_attr_chg_i};
  assign misc_en  = {aen_mask_r[fvec_pkg::AEN_FW_POS], aen_mask_r[fvec_pkg::AEN_NS_POS]};

  fvec_evt_gate #(
    .W (2)
  ) u_gate_misc (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .lvl_i  (misc_lvl),
    .en_i   (misc_en),
    .evt_o  (misc_evt)
  );

  fvec_evt_gate #(
    .W (fvec_pkg::AEN_HEALTH_W)
  ) u_gate_health (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .lvl_i  (health_warn_i),
    .en_i   (aen_mask_r[fvec_pkg::AEN_HEALTH_LSB +: fvec_pkg::AEN_HEALTH_W]),
    .evt_o  (aen_health_o)
  );

  assign aen_fw_act_o  = misc_evt[1];
  assign aen_ns_attr_o = misc_evt[0];

endmodule

// >>> test/fvec_feature_cfg_props.sv
`timescale 1ns/1ps
module fvec_feature_cfg_props (
  input wire logic                mclk_i,
  input wire logic                rst_i,
  input wire logic                cmd_valid_i,
  input wire fvec_pkg::fvec_cmd_t cmd_i,
  input wire fvec_pkg::fvec_post_t post_i,
  input wire logic                fw_act_start_i,
  input wire logic                ns_attr_chg_i,
  input wire logic [7:0]          health_warn_i,
  input wire logic                cpl_valid_o,
  input wire fvec_pkg::fvec_cpl_t cpl_o,
  input wire logic                post_valid_o,
  input wire logic                post_nocoal_o,
  input wire logic                normal_atomicity_off_o,
  input wire logic                honor_normal_atomic_o,
  input wire logic                aen_fw_act_o,
  input wire logic                aen_ns_attr_o,
  input wire logic [7:0]          aen_health_o
);
  logic fid_ok;
  assign fid_ok = cmd_i.fid inside {fvec_pkg::FID_VEC_CFG, fvec_pkg::FID_ATOMIC, fvec_pkg::FID_AEN};
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_known;
    cmd_valid_i && fid_ok;
  endsequence
  sequence s_atom_set;
    cmd_valid_i && cmd_i.set && cmd_i.fid == fvec_pkg::FID_ATOMIC;
  endsequence
  // echo comes first, the output flop one cycle after it
  property p_atom_path;
    logic b;
    (s_atom_set, b = cmd_i.dw11[0]) |-> ##1 cpl_o.dw0 == {31'h0, b} ##1 normal_atomicity_off_o == b;
  endproperty
  chk_known_answer: assert property (s_known |=> cpl_valid_o)
    else $error("decoded feature got no completion");
  chk_unknown_quiet: assert property (cmd_valid_i && !fid_ok |=> !cpl_valid_o)
    else $error("unknown feature answered");
  chk_vec_refuse: assert property (cmd_valid_i && cmd_i.fid == fvec_pkg::FID_VEC_CFG
    && cmd_i.dw11[15:0] >= 16'h0020 |=> cpl_o.status == fvec_pkg::STS_INVALID_FLD
    && cpl_o.dw0 == 32'h0) else $error("out of range vector not refused");
  chk_admin_nocoal: assert property (post_i.valid && post_i.admin |=> post_valid_o && post_nocoal_o)
    else $error("admin completion coalesced");
  chk_atom_path: assert property (p_atom_path) else $error("atomicity control path wrong");
  chk_honor_inverse: assert property (honor_normal_atomic_o != normal_atomicity_off_o)
    else $error("honor flag not inverse of disable");
  chk_fw_gate: assert property (aen_fw_act_o |-> $past(fw_act_start_i) && !$past(fw_act_start_i, 2))
    else $error("firmware notice without rising edge");
  chk_ns_gate: assert property ($rose(aen_ns_attr_o) |-> $past(ns_attr_chg_i))
    else $error("namespace notice without cause");
  chk_health_gate: assert property ((aen_health_o & ~$past(health_warn_i)) == 8'h00)
    else $error("health notice without warning");
endmodule
bind fvec_feature_cfg fvec_feature_cfg_props fvec_feature_cfg_props_inst (
  .mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .post_i(post_i),
  .fw_act_start_i(fw_act_start_i), .ns_attr_chg_i(ns_attr_chg_i), .health_warn_i(health_warn_i),
  .cpl_valid_o(cpl_valid_o), .cpl_o(cpl_o), .post_valid_o(post_valid_o),
  .post_nocoal_o(post_nocoal_o), .normal_atomicity_off_o(normal_atomicity_off_o),
  .honor_normal_atomic_o(honor_normal_atomic_o), .aen_fw_act_o(aen_fw_act_o),
  .aen_ns_attr_o(aen_ns_attr_o), .aen_health_o(aen_health_o));

// >>> test/fvec_host_model.sv
`timescale 1ns/1ps
module fvec_host_model (
  input  wire logic                  mclk_i,
  output logic                       cmd_valid_o,
  output fvec_pkg::fvec_cmd_t        cmd_o,
  output logic [fvec_pkg::NUM_VEC-1:0] iocq_ok_o
);
  // only vectors 0..7 own an i/o queue, so 8 and up exercise refusal
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
    iocq_ok_o = 32'h0000_00ff;
  end
  task automatic issue(input logic s, input logic [7:0] f, input logic [31:0] d);
    @(negedge mclk_i);
    cmd_valid_o = 1'b1;
    cmd_o = '{set: s, fid: f, dw11: d};
    @(negedge mclk_i);
    cmd_valid_o = 1'b0;
    cmd_o = ~cmd_o; // released fields show junk, not a stale command
  endtask
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
  logic                 mclk_i;
  logic                 rst_i;
  logic                 cmd_valid;
  fvec_pkg::fvec_cmd_t  cmd;
  logic [31:0]          iocq;
  fvec_pkg::fvec_post_t post;
  logic                 fw;
  logic                 ns;
  logic [7:0]           hw;
  logic                 cpl_valid;
  fvec_pkg::fvec_cpl_t  cpl;
  logic                 pv;
  logic                 pnc;
  logic [31:0]          coal;
  logic                 aoff;
  logic                 honor;
  logic                 afw;
  logic                 ans;
  logic [7:0]           ah;
  int                   miscompares;
  int                   check_count;
  localparam logic [7:0] OK = fvec_pkg::STS_SUCCESS;
  fvec_host_model fvec_host_model_inst (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
    .iocq_ok_o(iocq));
  fvec_feature_cfg fvec_feature_cfg_inst (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid),
    .cmd_i(cmd), .vec_iocq_ok_i(iocq), .post_i(post), .fw_act_start_i(fw), .ns_attr_chg_i(ns),
    .health_warn_i(hw), .cpl_valid_o(cpl_valid), .cpl_o(cpl), .post_valid_o(pv),
    .post_nocoal_o(pnc), .coalesce_off_vec_o(coal), .normal_atomicity_off_o(aoff),
    .honor_normal_atomic_o(honor), .aen_fw_act_o(afw), .aen_ns_attr_o(ans), .aen_health_o(ah));
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic rq(input logic s, input logic [7:0] f, input logic [31:0] d,
                    input logic [31:0] dw, input logic [7:0] st);
    fvec_host_model_inst.issue(s, f, d);
    `CHK(cpl_valid, 1'b1)
    `CHK(cpl.dw0, dw)
    `CHK(cpl.status, st)
  endtask
  task automatic send_post(input logic adm, input logic [15:0] v, input logic exp);
    @(negedge mclk_i);
    post = '{valid: 1'b1, admin: adm, vec: v};
    @(negedge mclk_i);
    post = '0;
    `CHK({pv, pnc}, {1'b1, exp})
  endtask
  task automatic evt(input logic [9:0] lv, input logic [9:0] ex);
    @(negedge mclk_i);
    {fw, ns, hw} = lv;
    @(negedge mclk_i);
    `CHK({afw, ans, ah}, ex)
    {fw, ns, hw} = 10'h000;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // whole run is about 56 cycles; a hang is cut at about 1000
  initial begin
    #4000;
    miscompares++;
    conclude();
  end
  initial begin
    rst_i = 1'b1;
    post = '0;
    {fw, ns, hw} = 10'h000;
    repeat (8) @(negedge mclk_i);
    rst_i = 1'b0;
    `CHK({coal, honor}, 33'h1)
    rq(1'b0, fvec_pkg::FID_ATOMIC, 32'h0, 32'h0, OK);
    rq(1'b1, fvec_pkg::FID_VEC_CFG, 32'hffff_0003, 32'h0001_0003, OK);
    @(negedge mclk_i);
    `CHK(coal, 32'h0000_0008)
    rq(1'b0, fvec_pkg::FID_VEC_CFG, 32'h0000_0003, 32'h0001_0003, OK);
    rq(1'b0, fvec_pkg::FID_VEC_CFG, 32'h0000_0005, 32'h0000_0005, OK);
    send_post(1'b0, 16'h0003, 1'b1);
    send_post(1'b0, 16'h0004, 1'b0);
    send_post(1'b1, 16'h0004, 1'b1);
    rq(1'b1, fvec_pkg::FID_VEC_CFG, 32'h0001_0009, 32'h0, fvec_pkg::STS_INVALID_FLD);
    rq(1'b1, fvec_pkg::FID_VEC_CFG, 32'h0001_0020, 32'h0, fvec_pkg::STS_INVALID_FLD);
    `CHK(coal, 32'h0000_0008)
    rq(1'b1, fvec_pkg::FID_ATOMIC, 32'hffff_ffff, 32'h1, OK);
    @(negedge mclk_i);
    `CHK({aoff, honor}, 2'b10)
    rq(1'b0, fvec_pkg::FID_ATOMIC, 32'h0, 32'h1, OK);
    rq(1'b1, fvec_pkg::FID_ATOMIC, 32'h0, 32'h0, OK);
    @(negedge mclk_i);
    `CHK({aoff, honor}, 2'b01)
    evt(10'h3ff, 10'h000);
    rq(1'b1, fvec_pkg::FID_AEN, 32'hffff_ffff, 32'h0000_03ff, OK);
    evt(10'h200, 10'h200);
    evt(10'h100, 10'h100);
    evt(10'h0a5, 10'h0a5);
    rq(1'b1, fvec_pkg::FID_AEN, 32'h0000_005a, 32'h0000_005a, OK);
    evt(10'h3ff, 10'h05a);
    rq(1'b0, fvec_pkg::FID_AEN, 32'h0, 32'h0000_005a, OK);
    fvec_host_model_inst.issue(1'b1, 8'h0c, 32'h1);
    `CHK(cpl_valid, 1'b0)
    rst_i = 1'b1;
    @(negedge mclk_i);
    rst_i = 1'b0;
    `CHK(coal, 32'h0)
    rq(1'b0, fvec_pkg::FID_AEN, 32'h0, 32'h0, OK);
    conclude();
  end
endmodule
